// ===== otc_pkg.sv
package otc_pkg;
   // clock and timing
   localparam int unsigned CLK_PERIOD_PS      = 100000;  // 10 MHz reference
   localparam int unsigned ASYNC_DLY_MIN_PS   = 2000;    // 2 ns
   localparam int unsigned ASYNC_DLY_MAX_PS   = 8500;    // 8.5 ns
   // least time rounds up, longest rounds down, never below one cycle
   localparam int unsigned ASYNC_MIN_CYC_RAW  = (ASYNC_DLY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ASYNC_MIN_CYC      = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
   localparam int unsigned ASYNC_MAX_CYC_RAW  = ASYNC_DLY_MAX_PS / CLK_PERIOD_PS;
   localparam int unsigned ASYNC_MAX_CYC      = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
   localparam int unsigned MIN_TERM_HIGH_SHORT = 4;      // write chop-four and plain assertion
   localparam int unsigned MIN_TERM_HIGH_LONG  = 6;      // write burst eight
   localparam int unsigned SYNC_LAT_OFFSET    = 2;       // on/off latency = write_latency - 2
   localparam int unsigned ANPD_OFFSET        = 1;       // entry/exit lead = write_latency - 1
   // widths and reset values
   localparam int unsigned CNT_W              = 8;
   localparam logic        PD_LOOP_SEL_RST    = 1'b0;    // loop frozen in precharge power-down

   typedef enum logic [1:0]
   {
      OTC_ST_ACTIVE = 2'b00,
      OTC_ST_ENTRY  = 2'b01,
      OTC_ST_PD     = 2'b10,
      OTC_ST_EXIT   = 2'b11
   } otc_state_t;
endpackage : otc_pkg

// ===== otc_dly_if.sv
`timescale 1ns/1ps
// one delay-line lane: enable request in, delayed enable out
interface otc_dly_if;
   logic in_lvl;
   logic sync_sel;
   logic out_lvl;
   modport ctl (output in_lvl, output sync_sel, input out_lvl);
   modport dly (input in_lvl, input sync_sel, output out_lvl);
endinterface : otc_dly_if

// ===== otc_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module otc_sync2
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic d_i,
   output logic      q_o
);
   typedef struct packed
   {
      logic s1;
      logic s2;
   } otc_sync_st_t;

   otc_sync_st_t st_q;
   otc_sync_st_t st_d;

   ////////////////////////////////////////////////////////////////
   // first stage only feeds second stage
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign q_o = st_q.s2;
endmodule : otc_sync2

// ===== otc_lat_line.sv
`timescale 1ns/1ps
// shift line giving the synchronous latency or the short asynchronous delay
module otc_lat_line #(
   parameter int unsigned DEPTH = 32
)
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic [otc_pkg::CNT_W-1:0] sync_lat_i,
   otc_dly_if.dly    lane
);
   typedef struct packed
   {
      logic [DEPTH-1:0] line;
      logic             out;
   } otc_lat_st_t;

   otc_lat_st_t st_q;
   otc_lat_st_t st_d;

   ////////////////////////////////////////////////////////////////
   // tap picks latency; asynchronous path uses the short fixed tap
   always_comb
   begin
      int unsigned tap;
      tap     = 0;
      st_d    = st_q;
      st_d.line = {st_q.line[DEPTH-2:0], lane.in_lvl};
      if (lane.sync_sel)
         tap = (int'(sync_lat_i) > 0) ? int'(sync_lat_i) - 1 : 0;
      else
         tap = otc_pkg::ASYNC_MIN_CYC - 1;
      if (tap > DEPTH - 1)
         tap = DEPTH - 1;  // clamp: latencies beyond the line saturate
      st_d.out = st_d.line[tap];
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign lane.out_lvl = st_q.out;
endmodule : otc_lat_line

// ===== otc_core.sv
`timescale 1ns/1ps
module otc_core #(
   parameter int unsigned WRITE_LATENCY   = 5,
   parameter int unsigned ADDITIVE_LAT    = 0,
   parameter int unsigned CKE_LOW_DLY     = 3,
   parameter int unsigned REFRESH_CYC     = 88,
   parameter int unsigned PD_EXIT_LOOP_DLY = 10
)
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic termination_enable_input_i,
   input  wire logic cke_i,
   input  wire logic write_cmd_i,
   input  wire logic write_chop_i,
   input  wire logic read_cmd_i,
   input  wire logic refresh_cmd_i,
   input  wire logic powerdown_loop_select_bit_i,
   output logic      term_on_o,
   output logic      async_mode_o,
   output logic      transition_o,
   output logic      hold_violation_o,
   output logic      pd_cmd_violation_o
);
   // lane latency and the lead before a cke edge, both in clock cycles;
   // an enable change inside that lead already counts as inside the period
   localparam int unsigned SYNC_LAT = WRITE_LATENCY - otc_pkg::SYNC_LAT_OFFSET;
   localparam int unsigned ANPD     = WRITE_LATENCY - otc_pkg::ANPD_OFFSET;

   typedef struct packed
   {
      otc_pkg::otc_state_t       st;
      logic                      loop_sel;
      logic                      term_prev;
      logic                      cke_prev;
      logic [otc_pkg::CNT_W-1:0] hold_cnt;
      logic [otc_pkg::CNT_W-1:0] hold_need;
      logic [otc_pkg::CNT_W-1:0] cke_low_cnt;
      logic [otc_pkg::CNT_W-1:0] ref_cnt;
      logic [otc_pkg::CNT_W-1:0] exit_cnt;
      logic [otc_pkg::CNT_W-1:0] lead_cnt;
      logic                      async;
      logic                      trans;
      logic                      term_on;
      logic                      hold_err;
      logic                      cmd_err;
   } otc_core_st_t;

   otc_core_st_t st_q;
   otc_core_st_t st_d;

   logic term_s;
   logic cke_s;
   logic wr_s;
   logic chop_s;
   logic rd_s;
   logic ref_s;
   logic sel_s;

   otc_dly_if sync_lane ();
   otc_dly_if async_lane ();

   ////////////////////////////////////////////////////////////////
   // all pins cross in through two flops before use
   // enable level: feeds both lanes and the high-time check
   otc_sync2 u_sync_term
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (termination_enable_input_i),
      .q_o      (term_s)
   );

   // power-down pin: its edges open the entry and exit periods
   otc_sync2 u_sync_cke
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (cke_i),
      .q_o      (cke_s)
   );

   // write strobe, restarts the high-time count
   otc_sync2 u_sync_wr
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (write_cmd_i),
      .q_o      (wr_s)
   );

   // chop flag, same delay as the write so the pair stays aligned
   otc_sync2 u_sync_chop
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (write_chop_i),
      .q_o      (chop_s)
   );

   // read strobe, only watched while powered down
   otc_sync2 u_sync_rd
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (read_cmd_i),
      .q_o      (rd_s)
   );

   // refresh strobe, opens the refresh window
   otc_sync2 u_sync_ref
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (refresh_cmd_i),
      .q_o      (ref_s)
   );

   // loop select; a slow strap, so the extra delay costs nothing
   otc_sync2 u_sync_sel
   (
      .ref_clk_i(ref_clk_i),
      .srst_i   (srst_i),
      .d_i      (powerdown_loop_select_bit_i),
      .q_o      (sel_s)
   );

   ////////////////////////////////////////////////////////////////
   // synchronous lane keeps write latency minus two plus additive latency; no additive latency
   // on the asynchronous lane, which is the point of that mode
   assign sync_lane.in_lvl   = term_s;
   assign sync_lane.sync_sel = 1'b1;
   assign async_lane.in_lvl  = term_s;
   assign async_lane.sync_sel = 1'b0;

   // pin to resistance: two synchroniser edges, the line, then the output flop;
   // the asynchronous lane therefore lands four edges after the pin moves
   otc_lat_line u_sync_line
   (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .sync_lat_i(otc_pkg::CNT_W'(SYNC_LAT + ADDITIVE_LAT)),
      .lane      (sync_lane)
   );

   otc_lat_line u_async_line
   (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .sync_lat_i(otc_pkg::CNT_W'(1)),
      .lane      (async_lane)
   );

   ////////////////////////////////////////////////////////////////
   // power-down mode tracking, transition windows and output select
   always_comb
   begin
      logic cke_fell;
      logic cke_rose;
      cke_fell = 1'b0;
      cke_rose = 1'b0;
      st_d = st_q;
      cke_fell = st_q.cke_prev & ~cke_s;
      cke_rose = ~st_q.cke_prev & cke_s;
      st_d.cke_prev  = cke_s;
      st_d.term_prev = term_s;
      // strap of the loop select is sampled only in the active state
      if (st_q.st == otc_pkg::OTC_ST_ACTIVE)
         st_d.loop_sel = sel_s;

      // refresh in progress counter
      if (ref_s)
         st_d.ref_cnt = otc_pkg::CNT_W'(REFRESH_CYC);
      else if (st_q.ref_cnt != '0)
         st_d.ref_cnt = st_q.ref_cnt - 1'b1;

      // lead counts cycles since the last enable change; a change within
      // the lead before cke edge falls inside the transition
      if (term_s != st_q.term_prev)
         st_d.lead_cnt = '0;
      else if (st_q.lead_cnt != '1)
         st_d.lead_cnt = st_q.lead_cnt + 1'b1;

      case (st_q.st)
         otc_pkg::OTC_ST_ACTIVE:
         begin
            if (cke_fell && !st_q.loop_sel)
            begin
               st_d.st          = otc_pkg::OTC_ST_ENTRY;
               st_d.cke_low_cnt = otc_pkg::CNT_W'(CKE_LOW_DLY - 1);
            end
            else if (st_q.exit_cnt != '0)
               st_d.exit_cnt = st_q.exit_cnt - 1'b1;
         end
         otc_pkg::OTC_ST_ENTRY:
         begin
            if (st_q.cke_low_cnt != '0)
               st_d.cke_low_cnt = st_q.cke_low_cnt - 1'b1;
            if (st_q.exit_cnt != '0)
               st_d.exit_cnt = st_q.exit_cnt - 1'b1;
            // end cycle is inside: step to power-down only once the cke-low, refresh and exit counts are spent
            if (st_q.cke_low_cnt == '0 && st_q.ref_cnt <= 1 && st_q.exit_cnt == '0)
               st_d.st = otc_pkg::OTC_ST_PD;
            if (cke_rose)
            begin
               st_d.st       = otc_pkg::OTC_ST_EXIT;
               st_d.exit_cnt = otc_pkg::CNT_W'(PD_EXIT_LOOP_DLY);
            end
         end
         otc_pkg::OTC_ST_PD:
         begin
            if (cke_rose)
            begin
               st_d.st       = otc_pkg::OTC_ST_EXIT;
               st_d.exit_cnt = otc_pkg::CNT_W'(PD_EXIT_LOOP_DLY);
            end
         end
         otc_pkg::OTC_ST_EXIT:
         begin
            if (st_q.exit_cnt != '0)
               st_d.exit_cnt = st_q.exit_cnt - 1'b1;
            if (st_q.exit_cnt <= 1)
               st_d.st = otc_pkg::OTC_ST_ACTIVE;
            if (cke_fell && !st_q.loop_sel)
            begin
               st_d.st          = otc_pkg::OTC_ST_ENTRY;
               st_d.cke_low_cnt = otc_pkg::CNT_W'(CKE_LOW_DLY - 1);
            end
         end
         default:
            st_d.st = otc_pkg::OTC_ST_ACTIVE;
      endcase

      // transition span covers entry, exit and a direct step from active into power-down
      st_d.trans = (st_d.st == otc_pkg::OTC_ST_ENTRY) || (st_d.st == otc_pkg::OTC_ST_EXIT)
                   || (st_d.st == otc_pkg::OTC_ST_PD && st_q.st == otc_pkg::OTC_ST_ACTIVE);
      st_d.async = (st_d.st == otc_pkg::OTC_ST_PD);

      // inside transitions either lane is legal; turning on with the earlier lane
      // and off with the later one keeps both bounds (min of minima, max of maxima) honoured
      if (st_q.async)
         st_d.term_on = async_lane.out_lvl;
      else if (st_q.trans && st_q.lead_cnt < otc_pkg::CNT_W'(ANPD))
         st_d.term_on = async_lane.out_lvl | (sync_lane.out_lvl & st_q.term_on);
      else
         st_d.term_on = sync_lane.out_lvl;

      // minimum enable high time check, set wins over clear
      if (term_s && !st_q.term_prev)
      begin
         st_d.hold_cnt  = '0;
         st_d.hold_need = otc_pkg::CNT_W'(otc_pkg::MIN_TERM_HIGH_SHORT);
      end
      else if (term_s && st_q.hold_cnt != '1)
         st_d.hold_cnt = st_q.hold_cnt + 1'b1;
      if (term_s && wr_s)
      begin
         st_d.hold_cnt  = '0;
         st_d.hold_need = chop_s ? otc_pkg::CNT_W'(otc_pkg::MIN_TERM_HIGH_SHORT)
                                 : otc_pkg::CNT_W'(otc_pkg::MIN_TERM_HIGH_LONG);
      end
      // widened sum: a saturated count must not wrap to zero and flag a long high spell
      st_d.hold_err = !term_s && st_q.term_prev
                      && ({1'b0, st_q.hold_cnt} + 9'h001 < {1'b0, st_q.hold_need});

      // reads or writes while powered down are flagged, enable still heard
      st_d.cmd_err = (st_q.st == otc_pkg::OTC_ST_PD) && (rd_s || wr_s);
   end

   // one register for all state; reset parks the loop select at its frozen default
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         st_q          <= '0;
         st_q.st       <= otc_pkg::OTC_ST_ACTIVE;
         st_q.loop_sel <= otc_pkg::PD_LOOP_SEL_RST;
      end
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////
   // every output straight from the state register
   assign term_on_o          = st_q.term_on;
   assign async_mode_o       = st_q.async;
   assign transition_o       = st_q.trans;
   assign hold_violation_o   = st_q.hold_err;
   assign pd_cmd_violation_o = st_q.cmd_err;
endmodule : otc_core

// ===== otc_core_asserts.sv
`timescale 1ns/1ps
// watches the termination control ports only
module otc_core_asserts #(
   parameter int unsigned WRITE_LATENCY    = 5,
   parameter int unsigned ADDITIVE_LAT     = 0,
   parameter int unsigned CKE_LOW_DLY      = 3,
   parameter int unsigned REFRESH_CYC      = 88,
   parameter int unsigned PD_EXIT_LOOP_DLY = 10
)
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic termination_enable_input_i,
   input wire logic cke_i,
   input wire logic write_cmd_i,
   input wire logic write_chop_i,
   input wire logic read_cmd_i,
   input wire logic refresh_cmd_i,
   input wire logic powerdown_loop_select_bit_i,
   input wire logic term_on_o,
   input wire logic async_mode_o,
   input wire logic transition_o,
   input wire logic hold_violation_o,
   input wire logic pd_cmd_violation_o
);
   localparam int SYNC_DEPTH = WRITE_LATENCY + ADDITIVE_LAT + 1;
   logic [7:0] steady_q;
   logic [7:0] ckelo_q;
   logic [7:0] ref_q;
   logic [7:0] tlen_q;
   ////////////////////////////////////////////////////////////////////////////////
   // saturating ages, so a long idle spell never wraps into a false hit
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         steady_q <= 8'h00;
         ckelo_q  <= 8'h00;
         ref_q    <= 8'hFF;
         tlen_q   <= 8'h00;
      end
      else
      begin
         steady_q <= (async_mode_o || transition_o) ? 8'h00 : steady_q + 8'(steady_q != 8'hFF);
         ckelo_q  <= cke_i ? 8'h00 : ckelo_q + 8'(ckelo_q != 8'hFF);
         ref_q    <= refresh_cmd_i ? 8'h00 : ref_q + 8'(ref_q != 8'hFF);
         tlen_q   <= transition_o ? tlen_q + 8'(tlen_q != 8'hFF) : 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_pd_steady;
      (async_mode_o && !transition_o) [*5];
   endsequence
   sequence s_enter;
      !async_mode_o && !transition_o && !powerdown_loop_select_bit_i && $fell(cke_i);
   endsequence
   sequence s_leave;
      async_mode_o && $rose(cke_i);
   endsequence
   a_sync_lat: assert property (steady_q >= 8'd8 |-> term_on_o == $past(termination_enable_input_i, SYNC_DEPTH))
      else $error("synchronous latency wrong");
   a_async_lat: assert property (s_pd_steady |-> term_on_o == $past(termination_enable_input_i, 4))
      else $error("asynchronous delay wrong");
   a_entry_start: assert property (s_enter |-> ##3 transition_o)
      else $error("entry period missing");
   a_sel_block: assert property (!async_mode_o && !transition_o && powerdown_loop_select_bit_i && $fell(cke_i)
      |-> (!async_mode_o && !transition_o) [*6])
      else $error("loop kept on yet mode changed");
   a_cke_delay: assert property ($rose(async_mode_o) |-> ckelo_q >= CKE_LOW_DLY)
      else $error("entry period ended early");
   a_refresh_wait: assert property ($rose(async_mode_o) |-> ref_q + 1 >= REFRESH_CYC)
      else $error("entry ended inside refresh");
   a_exit_start: assert property (s_leave |-> ##3 (transition_o && !async_mode_o) [*8])
      else $error("exit period wrong");
   a_exit_len: assert property ($fell(transition_o) && !async_mode_o |-> tlen_q >= PD_EXIT_LOOP_DLY)
      else $error("exit period too short");
   a_pd_cmd: assert property (async_mode_o && (read_cmd_i || write_cmd_i) ##1 async_mode_o [*3]
      |-> ##[0:2] pd_cmd_violation_o)
      else $error("command in power-down not flagged");
   a_hold_flag: assert property ($rose(termination_enable_input_i) && !transition_o ##1 !termination_enable_input_i [*3]
      |-> ##[0:3] hold_violation_o)
      else $error("short enable not flagged");
endmodule : otc_core_asserts

bind otc_core otc_core_asserts #(.WRITE_LATENCY(WRITE_LATENCY), .ADDITIVE_LAT(ADDITIVE_LAT),
   .CKE_LOW_DLY(CKE_LOW_DLY), .REFRESH_CYC(REFRESH_CYC), .PD_EXIT_LOOP_DLY(PD_EXIT_LOOP_DLY)) chk_u
   (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .termination_enable_input_i(termination_enable_input_i),
    .cke_i(cke_i), .write_cmd_i(write_cmd_i), .write_chop_i(write_chop_i), .read_cmd_i(read_cmd_i),
    .refresh_cmd_i(refresh_cmd_i), .powerdown_loop_select_bit_i(powerdown_loop_select_bit_i),
    .term_on_o(term_on_o), .async_mode_o(async_mode_o), .transition_o(transition_o),
    .hold_violation_o(hold_violation_o), .pd_cmd_violation_o(pd_cmd_violation_o));

// ===== otc_ctl_model.sv
`timescale 1ns/1ps
// controller side: turns bench requests into pins, keeping the high-time minimums
module otc_ctl_model
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic strict_i,    // low lets the bench break controller rules
   input  wire logic want_term_i,
   input  wire logic want_cke_i,
   input  wire logic wr_req_i,
   input  wire logic chop_i,
   input  wire logic rd_req_i,
   input  wire logic ref_req_i,
   output logic      term_o,
   output logic      cke_o,
   output logic      wr_o,
   output logic      chop_o,
   output logic      rd_o,
   output logic      ref_o
);
   logic [2:0] hold_q;
   logic [2:0] hold_d;
   logic       term_d;
   // remaining forced-high cycles; a write may only lengthen the hold
   always_comb
   begin
      term_d = want_term_i || (strict_i && hold_q != 3'h0);
      hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      if (term_d && !term_o)
         hold_d = 3'h3;
      if (wr_req_i && term_d)
         hold_d = chop_i ? ((hold_d > 3'h3) ? hold_d : 3'h3) : 3'h5;
   end
   // pins change only just after an edge
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         hold_q <= 3'h0;
         term_o <= 1'b0;
         cke_o  <= 1'b1;
         wr_o   <= 1'b0;
         chop_o <= 1'b0;
         rd_o   <= 1'b0;
         ref_o  <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         term_o <= term_d;
         cke_o  <= want_cke_i;
         wr_o   <= wr_req_i && (cke_o || !strict_i);
         chop_o <= chop_i;
         rd_o   <= rd_req_i && (cke_o || !strict_i);
         ref_o  <= ref_req_i;
      end
   end
endmodule : otc_ctl_model

// ===== otc_core_test.sv
`timescale 1ns/1ps
module otc_core_test;
   localparam int WL = 5;
   localparam int AL = 2;
   localparam int REF_CYC = 20;
   localparam int EXIT_DLY = 10;
   localparam int EDGE_EXP = 5;    // model flop, then three edges after cke is seen
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic strict = 1'b1, want_term = 1'b0, want_cke = 1'b1, wr_req = 1'b0, chop_req = 1'b0;
   logic rd_req = 1'b0, ref_req = 1'b0, sel_bit = 1'b0;
   logic term_pin, cke_pin, wr_pin, chop_pin, rd_pin, ref_pin;
   logic term_on_o, async_mode_o, transition_o, hold_violation_o, pd_cmd_violation_o;
   int   n_fail = 0, cmp_count = 0, cyc = 0, n_hold = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   // violation pulses tallied at the falling edge, where the flag has settled
   always @(negedge ref_clk_i)
      if (hold_violation_o === 1'b1)
         n_hold++;
   otc_ctl_model model_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .strict_i(strict), .want_term_i(want_term),
      .want_cke_i(want_cke), .wr_req_i(wr_req), .chop_i(chop_req), .rd_req_i(rd_req), .ref_req_i(ref_req),
      .term_o(term_pin), .cke_o(cke_pin), .wr_o(wr_pin), .chop_o(chop_pin), .rd_o(rd_pin), .ref_o(ref_pin));
   otc_core #(.WRITE_LATENCY(WL), .ADDITIVE_LAT(AL), .REFRESH_CYC(REF_CYC), .PD_EXIT_LOOP_DLY(EXIT_DLY)) dut_u
     (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .termination_enable_input_i(term_pin), .cke_i(cke_pin),
      .write_cmd_i(wr_pin), .write_chop_i(chop_pin), .read_cmd_i(rd_pin), .refresh_cmd_i(ref_pin),
      .powerdown_loop_select_bit_i(sel_bit), .term_on_o(term_on_o), .async_mode_o(async_mode_o),
      .transition_o(transition_o), .hold_violation_o(hold_violation_o), .pd_cmd_violation_o(pd_cmd_violation_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   function automatic logic pick(input int s);
      case (s)
         0: pick = term_pin;
         1: pick = term_on_o;
         2: pick = async_mode_o;
         3: pick = transition_o;
         4: pick = hold_violation_o;
         default: pick = pd_cmd_violation_o;
      endcase
   endfunction : pick
   // counts falling edges until the chosen signal reaches lvl, bounded
   task automatic wait_for(input int s, input logic lvl, output int n);
      n = 0;
      while (pick(s) !== lvl && n < 300)
      begin
         @(negedge ref_clk_i);
         n++;
      end
   endtask : wait_for
   // enable on then off, latency from pin to resistance both ways
   task automatic sc_term(input int exp);
      int n;
      @(posedge ref_clk_i) want_term <= 1'b1;
      wait_for(0, 1'b1, n);
      wait_for(1, 1'b1, n);
      check(16'(n), 16'(exp));
      @(posedge ref_clk_i) want_term <= 1'b0;
      wait_for(0, 1'b0, n);
      wait_for(1, 1'b0, n);
      check(16'(n), 16'(exp));
   endtask : sc_term
   // one-cycle request, the controller stretches the high time
   task automatic sc_hold(input logic wr, input logic chop, input int exp);
      int n;
      int base;
      base = n_hold;
      @(posedge ref_clk_i);
      want_term <= 1'b1;
      wr_req    <= wr;
      chop_req  <= chop;
      @(posedge ref_clk_i);
      want_term <= 1'b0;
      wr_req    <= 1'b0;
      wait_for(0, 1'b1, n);
      wait_for(0, 1'b0, n);
      check(16'(n), 16'(exp));
      repeat (8) @(posedge ref_clk_i);
      check(16'(n_hold - base), 16'h0000);
   endtask : sc_hold
   // controller drops enable after one cycle
   task automatic sc_short;
      int n;
      @(posedge ref_clk_i);
      strict    <= 1'b0;
      want_term <= 1'b1;
      @(posedge ref_clk_i) want_term <= 1'b0;
      wait_for(4, 1'b1, n);
      check(16'(n < 10), 16'h0001);
      @(posedge ref_clk_i) strict <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
   endtask : sc_short
   task automatic sc_exit;
      int n;
      @(posedge ref_clk_i) want_cke <= 1'b1;
      wait_for(3, 1'b1, n);
      check(16'(n), 16'(EDGE_EXP));
      wait_for(3, 1'b0, n);
      check(16'(n), 16'(EXIT_DLY));
      check({15'h0000, async_mode_o}, 16'h0000);
      repeat (12) @(posedge ref_clk_i);
   endtask : sc_exit
   // power-down with frozen loop: entry, async latency, illegal commands, exit
   task automatic sc_pd;
      int n;
      @(posedge ref_clk_i) want_cke <= 1'b0;
      wait_for(3, 1'b1, n);
      check(16'(n), 16'(EDGE_EXP));
      wait_for(2, 1'b1, n);
      check({15'h0000, transition_o}, 16'h0000);
      sc_term(4);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge ref_clk_i);
         strict <= 1'b0;
         rd_req <= (k == 0);
         wr_req <= (k == 1);
         @(posedge ref_clk_i);
         rd_req <= 1'b0;
         wr_req <= 1'b0;
         wait_for(5, 1'b1, n);
         check(16'(n < 6), 16'h0001);
      end
      @(posedge ref_clk_i) strict <= 1'b1;
      sc_exit();
   endtask : sc_pd
   // refresh right before entry keeps the transition open
   task automatic sc_refresh;
      int n;
      @(posedge ref_clk_i) ref_req <= 1'b1;
      @(posedge ref_clk_i);
      ref_req  <= 1'b0;
      want_cke <= 1'b0;
      wait_for(2, 1'b1, n);
      check(16'(n >= REF_CYC), 16'h0001);
      sc_exit();
   endtask : sc_refresh
   // loop left running: no mode change at all
   task automatic sc_sel;
      @(posedge ref_clk_i) sel_bit <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      want_cke <= 1'b0;
      repeat (12) @(negedge ref_clk_i);
      check({14'h0000, async_mode_o, transition_o}, 16'h0000);
      @(posedge ref_clk_i) want_cke <= 1'b1;
      repeat (12) @(posedge ref_clk_i);
      sel_bit <= 1'b0;
   endtask : sc_sel
   // two-cycle power-down: entry and exit periods merge
   task automatic sc_overlap;
      int n;
      @(posedge ref_clk_i) want_cke <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      want_cke <= 1'b1;
      wait_for(3, 1'b1, n);
      wait_for(3, 1'b0, n);
      check(16'(n), 16'(2 + EXIT_DLY));
      repeat (12) @(posedge ref_clk_i);
   endtask : sc_overlap
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      sc_term(WL + AL + 1);
      sc_hold(1'b1, 1'b0, 6);
      sc_hold(1'b1, 1'b1, 4);
      sc_hold(1'b0, 1'b0, 4);
      sc_short();
      sc_pd();
      sc_term(WL + AL + 1);
      sc_refresh();
      sc_sel();
      sc_overlap();
      stop_test();
   end
endmodule : otc_core_test
